// >>> core/touch_pkg.sv
// constants, carriers and helper functions for the touch scan scheduler
// and strongest-touch selection; shared by the top and the selector
package touch_pkg;

    localparam int NUM_SENSORS = 8;
    localparam int CAP_W       = 16;
    localparam int ADDR_W      = 12;

    // register offsets
    localparam logic [11:0] ADDR_HARD_RESET   = 12'h000;
    localparam logic [11:0] ADDR_SOFT_RESET   = 12'h001;
    localparam logic [11:0] ADDR_POWER_CFG    = 12'h002;
    localparam logic [11:0] ADDR_SLEEP_WAIT   = 12'h003;
    localparam logic [11:0] ADDR_HOLD_TIME    = 12'h028;
    localparam logic [11:0] ADDR_TOUCH_CFG    = 12'h040;
    localparam logic [11:0] ADDR_SLEEP_PERIOD = 12'h056;
    localparam logic [11:0] ADDR_RANKING_CFG  = 12'h075;

    // field positions
    localparam int LOW_POWER_BIT    = 1;
    localparam int LIMIT_SINGLE_BIT = 8;
    localparam int LIMIT_TWO_BIT    = 9;
    localparam int RELATIVE_BIT     = 15;

    // reset values
    localparam logic [15:0] POWER_CFG_RST    = 16'h0000;
    localparam logic [15:0] SLEEP_WAIT_RST   = 16'h0000;
    localparam logic [15:0] HOLD_TIME_RST    = 16'h0000;
    localparam logic [15:0] TOUCH_CFG_RST    = 16'h0000;
    localparam logic [15:0] SLEEP_PERIOD_RST = 16'h0000;
    localparam logic [15:0] RANKING_CFG_RST  = 16'h0000;

    // timing
    localparam int CLK_PERIOD_NS        = 10;
    localparam int SCAN_PER_SENSOR_NS   = 2_000_000;
    localparam int MS_NS                = 1_000_000;
    localparam int SCAN_PER_SENSOR_CYC  = SCAN_PER_SENSOR_NS / CLK_PERIOD_NS;
    localparam int MS_CYC               = MS_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [NUM_SENSORS-1:0][CAP_W-1:0] cap;
        logic [NUM_SENSORS-1:0][CAP_W-1:0] thr;
        logic [NUM_SENSORS-1:0]            touched;
    } sensor_sample_t;

    typedef struct packed {
        logic [15:0] power;
        logic [15:0] sleep_wait;
        logic [15:0] hold;
        logic [15:0] touch;
        logic [15:0] sleep_period;
        logic [15:0] ranking;
    } cfg_t;

    typedef enum logic [2:0] {
        PH_CAL   = 3'b001,
        PH_SCAN  = 3'b010,
        PH_SLEEP = 3'b100
    } phase_t;

    function automatic logic signed [CAP_W:0] strength(
        input logic [CAP_W-1:0] cap,
        input logic [CAP_W-1:0] thr,
        input logic             relative
    );
        logic signed [CAP_W:0] c;
        logic signed [CAP_W:0] t;
        c = $signed({1'b0, cap});
        t = $signed({1'b0, thr});
        return relative ? c - t : c;
    endfunction

    function automatic logic [3:0] count_active(input logic [NUM_SENSORS-1:0] mask);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < NUM_SENSORS; i++) begin
            n = n + {3'h0, mask[i]};
        end
        return n;
    endfunction

    function automatic logic [NUM_SENSORS-1:0] one_hot(
        input logic [2:0] idx,
        input logic       valid
    );
        return valid ? (8'h01 << idx) : 8'h00;
    endfunction

endpackage

// >>> core/strongest_select.sv
// ranks qualifying touches and returns the strongest and second strongest
// assumes a sample that is stable for the cycle in which it is read
`timescale 1ns/1ps
`default_nettype none
module strongest_select (
    input  wire touch_pkg::sensor_sample_t sample,
    input  wire logic                      relative,
    output logic [7:0]                     qualify,
    output logic [2:0]                     best_idx,
    output logic                           best_valid,
    output logic [2:0]                     second_idx,
    output logic                           second_valid
);
    logic signed [16:0] best_s;
    logic signed [16:0] second_s;
    logic signed [16:0] s;

    always_comb begin
        qualify      = 8'h00;
        best_idx     = 3'h0;
        best_valid   = 1'b0;
        second_idx   = 3'h0;
        second_valid = 1'b0;
        best_s       = '0;
        second_s     = '0;
        s            = '0;
        // ties go to the lower sensor index so ranking is deterministic
        for (int i = 0; i < touch_pkg::NUM_SENSORS; i++) begin
            s = touch_pkg::strength(sample.cap[i], sample.thr[i], relative);
            qualify[i] = sample.touched[i] && (sample.cap[i] > sample.thr[i]);
            if (qualify[i]) begin
                if (!best_valid || s > best_s) begin
                    second_idx   = best_idx;
                    second_valid = best_valid;
                    second_s     = best_s;
                    best_idx     = 3'(i);
                    best_valid   = 1'b1;
                    best_s       = s;
                end else if (!second_valid || s > second_s) begin
                    second_idx   = 3'(i);
                    second_valid = 1'b1;
                    second_s     = s;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> core/touch_scan_control.sv
// low power scan scheduler and selective touch filter
// assumes the converter delivers a settled sample on the same clock and
// that the serial interface turns host accesses into one-cycle strobes
//
// Overview of operation
// - power bit 1 enables sleep/scan alternation
// - scan lasts 2 ms per active sensor
// - sleep lasts sleep register value in ms
// - after touch, stay full power for wait time
// - unrestricted mode reports every above-threshold touch
// - single mode reports strongest above-threshold touch
// - two mode reports two strongest touches
// - relative modes rank capacitance minus threshold
// - touch bits 8/9 select single or two
// - limiting bits clear at power up
// - ranking bit 15 picks absolute or relative
// - stronger touch replaces only after hold time
// - hold time ignored in two strongest modes
// - soft reset restarts sequencing, keeps configuration
`timescale 1ns/1ps
`default_nettype none
module touch_scan_control #(
    parameter int unsigned SCAN_CYC = touch_pkg::SCAN_PER_SENSOR_CYC,
    parameter int unsigned MS_CYC   = touch_pkg::MS_CYC
) (
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic                      hardware_reset_pin_n,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [11:0]               reg_addr,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic [7:0]                sensor_active,
    input  wire touch_pkg::sensor_sample_t sample,
    output logic [15:0]                    reg_rdata,
    output logic                           scan_enable,
    output logic                           scan_done,
    output logic                           calib_restart,
    output logic [7:0]                     touch_report
);
    typedef struct packed {
        logic              pin_meta;
        logic              pin_sync;
        touch_pkg::cfg_t   cfg;
        touch_pkg::phase_t phase;
        logic [23:0]       scan_cnt;
        logic [23:0]       sleep_cnt;
        logic [15:0]       sleep_ms;
        logic [23:0]       tick_cnt;
        logic [15:0]       wait_ms;
        logic [2:0]        cur_idx;
        logic              cur_valid;
        logic [15:0]       hold_cnt;
        logic [7:0]        touch_report;
        logic              scan_enable;
        logic              scan_done;
        logic              calib_restart;
        logic [15:0]       reg_rdata;
    } state_t;

    localparam touch_pkg::cfg_t CFG_RST = '{
        power:        touch_pkg::POWER_CFG_RST,
        sleep_wait:   touch_pkg::SLEEP_WAIT_RST,
        hold:         touch_pkg::HOLD_TIME_RST,
        touch:        touch_pkg::TOUCH_CFG_RST,
        sleep_period: touch_pkg::SLEEP_PERIOD_RST,
        ranking:      touch_pkg::RANKING_CFG_RST
    };
    localparam logic [23:0] MS_LAST = 24'(MS_CYC - 1);

    state_t      st;
    state_t      next_st;
    logic [7:0]  qualify;
    logic [2:0]  best_idx;
    logic        best_valid;
    logic [2:0]  second_idx;
    logic        second_valid;
    logic [23:0] scan_total;
    logic        low_power;
    logic        mode_single;
    logic        mode_two;
    logic        relative;
    logic        scan_end;
    logic        ms_tick;
    logic        soft_hit;
    logic        hard_hit;
    logic [15:0] wait_after;

    function automatic logic [15:0] read_reg(input touch_pkg::cfg_t c, input logic [11:0] a);
        case (a)
            touch_pkg::ADDR_POWER_CFG:    return c.power;
            touch_pkg::ADDR_SLEEP_WAIT:   return c.sleep_wait;
            touch_pkg::ADDR_HOLD_TIME:    return c.hold;
            touch_pkg::ADDR_TOUCH_CFG:    return c.touch;
            touch_pkg::ADDR_SLEEP_PERIOD: return c.sleep_period;
            touch_pkg::ADDR_RANKING_CFG:  return c.ranking;
            default:                      return 16'h0000;
        endcase
    endfunction

    strongest_select u_select (
        .sample       (sample),
        .relative     (relative),
        .qualify      (qualify),
        .best_idx     (best_idx),
        .best_valid   (best_valid),
        .second_idx   (second_idx),
        .second_valid (second_valid)
    );

    always_comb begin
        low_power   = st.cfg.power[touch_pkg::LOW_POWER_BIT];
        // limiting mode decode; 1/1 falls to all-touch
        mode_single = st.cfg.touch[touch_pkg::LIMIT_SINGLE_BIT]
                      && !st.cfg.touch[touch_pkg::LIMIT_TWO_BIT];
        mode_two    = !st.cfg.touch[touch_pkg::LIMIT_SINGLE_BIT]
                      && st.cfg.touch[touch_pkg::LIMIT_TWO_BIT];
        relative    = st.cfg.ranking[touch_pkg::RELATIVE_BIT];
        scan_total  = 24'(touch_pkg::count_active(sensor_active) * SCAN_CYC);
        scan_end    = (scan_total == 24'h00_0000) || (st.scan_cnt >= scan_total - 24'h00_0001);
        ms_tick     = (st.tick_cnt == MS_LAST);
        soft_hit    = reg_wr && (reg_addr == touch_pkg::ADDR_SOFT_RESET);
        hard_hit    = (reg_wr && (reg_addr == touch_pkg::ADDR_HARD_RESET)) || !st.pin_sync;
        wait_after  = 16'h0000;

        next_st               = st;
        next_st.scan_done     = 1'b0;
        next_st.calib_restart = 1'b0;
        next_st.pin_meta      = hardware_reset_pin_n;
        next_st.pin_sync      = st.pin_meta;
        if (reg_rd) begin
            next_st.reg_rdata = read_reg(st.cfg, reg_addr);
        end
        if (reg_wr) begin
            case (reg_addr)
                touch_pkg::ADDR_POWER_CFG:    next_st.cfg.power        = reg_wdata;
                touch_pkg::ADDR_SLEEP_WAIT:   next_st.cfg.sleep_wait   = reg_wdata;
                touch_pkg::ADDR_HOLD_TIME:    next_st.cfg.hold         = reg_wdata;
                touch_pkg::ADDR_TOUCH_CFG:    next_st.cfg.touch        = reg_wdata;
                touch_pkg::ADDR_SLEEP_PERIOD: next_st.cfg.sleep_period = reg_wdata;
                touch_pkg::ADDR_RANKING_CFG:  next_st.cfg.ranking      = reg_wdata;
                default: ;
            endcase
        end

        unique case (st.phase)
            touch_pkg::PH_CAL: begin
                next_st.phase       = touch_pkg::PH_SCAN;
                next_st.scan_enable = 1'b1;
                next_st.scan_cnt    = 24'h00_0000;
            end
            touch_pkg::PH_SCAN: begin
                next_st.scan_cnt = st.scan_cnt + 24'h00_0001;
                next_st.tick_cnt = ms_tick ? 24'h00_0000 : st.tick_cnt + 24'h00_0001;
                if (ms_tick && st.wait_ms != 16'h0000) begin
                    next_st.wait_ms = st.wait_ms - 16'h0001;
                end
                if (scan_end) begin
                    next_st.scan_done = 1'b1;
                    next_st.scan_cnt  = 24'h00_0000;
                    wait_after        = next_st.wait_ms;
                    // touch rearms the full power wait
                    if (|qualify) begin
                        next_st.wait_ms  = st.cfg.sleep_wait;
                        next_st.tick_cnt = 24'h00_0000;
                        wait_after       = st.cfg.sleep_wait;
                    end
                    if (mode_single) begin
                        next_st.touch_report = touch_pkg::one_hot(best_idx, best_valid);
                        if (!best_valid) begin
                            next_st.cur_valid    = 1'b0;
                            next_st.hold_cnt     = 16'h0000;
                            next_st.touch_report = 8'h00;
                        end else if (!st.cur_valid || !qualify[st.cur_idx]
                                     || best_idx == st.cur_idx) begin
                            next_st.cur_idx   = best_idx;
                            next_st.cur_valid = 1'b1;
                            next_st.hold_cnt  = 16'h0000;
                        end else if (st.hold_cnt >= st.cfg.hold) begin
                            next_st.cur_idx  = best_idx;
                            next_st.hold_cnt = 16'h0000;
                        end else begin
                            next_st.hold_cnt     = st.hold_cnt + 16'h0001;
                            next_st.touch_report = touch_pkg::one_hot(st.cur_idx, 1'b1);
                        end
                    end else begin
                        next_st.hold_cnt  = 16'h0000;
                        next_st.cur_valid = 1'b0;
                        next_st.touch_report = mode_two
                            ? (touch_pkg::one_hot(best_idx, best_valid)
                               | touch_pkg::one_hot(second_idx, second_valid))
                            : qualify;
                    end
                    // sleep only once the wait has lapsed
                    if (low_power && wait_after == 16'h0000
                        && st.cfg.sleep_period != 16'h0000) begin
                        next_st.phase       = touch_pkg::PH_SLEEP;
                        next_st.scan_enable = 1'b0;
                        next_st.sleep_ms    = st.cfg.sleep_period;
                        next_st.sleep_cnt   = 24'h00_0000;
                    end
                end
            end
            touch_pkg::PH_SLEEP: begin
                // count sleep in 1 ms steps
                next_st.sleep_cnt = st.sleep_cnt + 24'h00_0001;
                if (st.sleep_cnt == MS_LAST) begin
                    next_st.sleep_cnt = 24'h00_0000;
                    next_st.sleep_ms  = st.sleep_ms - 16'h0001;
                end
                if (!low_power || (st.sleep_cnt == MS_LAST && st.sleep_ms <= 16'h0001)) begin
                    next_st.phase       = touch_pkg::PH_SCAN;
                    next_st.scan_enable = 1'b1;
                    next_st.scan_cnt    = 24'h00_0000;
                    next_st.tick_cnt    = 24'h00_0000;
                end
            end
            default: begin
                next_st.phase = touch_pkg::PH_CAL;
            end
        endcase

        // restart sequencing, configuration survives a soft reset
        if (soft_hit || hard_hit) begin
            next_st.phase         = touch_pkg::PH_CAL;
            next_st.calib_restart = 1'b1;
            next_st.scan_enable   = 1'b0;
            next_st.scan_done     = 1'b0;
            next_st.scan_cnt      = 24'h00_0000;
            next_st.sleep_cnt     = 24'h00_0000;
            next_st.sleep_ms      = 16'h0000;
            next_st.tick_cnt      = 24'h00_0000;
            next_st.wait_ms       = 16'h0000;
            next_st.cur_valid     = 1'b0;
            next_st.cur_idx       = 3'h0;
            next_st.hold_cnt      = 16'h0000;
            next_st.touch_report  = 8'h00;
        end
        if (hard_hit) begin
            next_st.cfg = CFG_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st          <= '0;
            st.cfg      <= CFG_RST;
            st.pin_meta <= 1'b1;
            st.pin_sync <= 1'b1;
            st.phase    <= touch_pkg::PH_CAL;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.reg_rdata;
    assign scan_enable   = st.scan_enable;
    assign scan_done     = st.scan_done;
    assign calib_restart = st.calib_restart;
    assign touch_report  = st.touch_report;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_sleep_needs_lp: assert property (
        (st.phase == touch_pkg::PH_SLEEP && !low_power && !soft_hit && !hard_hit)
        |=> st.phase == touch_pkg::PH_SCAN && st.scan_enable)
        else $error("sleep held with low power off");
    chk_scan_length: assert property (
        (st.scan_done && $past(scan_total) != 24'h00_0000)
        |-> $past(st.scan_cnt) == $past(scan_total) - 24'h00_0001)
        else $error("scan cycle length wrong");
    chk_sleep_ms_step: assert property (
        (st.phase == touch_pkg::PH_SLEEP && st.sleep_cnt == MS_LAST && st.sleep_ms > 16'h0001
         && low_power && !soft_hit && !hard_hit)
        |=> st.phase == touch_pkg::PH_SLEEP && st.sleep_ms == $past(st.sleep_ms) - 16'h0001)
        else $error("sleep millisecond step wrong");
    chk_wait_no_sleep: assert property (
        (st.phase == touch_pkg::PH_SCAN && st.wait_ms > 16'h0001)
        |=> st.phase != touch_pkg::PH_SLEEP)
        else $error("slept during full power wait");
    chk_all_report: assert property (
        (st.scan_done && !$past(mode_single) && !$past(mode_two))
        |-> st.touch_report == $past(qualify))
        else $error("all-touch report mismatch");
    chk_single_onehot: assert property (
        (st.scan_done && $past(mode_single)) |-> $onehot0(st.touch_report))
        else $error("single mode reported several");
    chk_two_count: assert property (
        (st.scan_done && $past(mode_two)) |-> $countones(st.touch_report) <= 2)
        else $error("two mode reported more than two");
    chk_limit_reset: assert property (
        $fell(reset) |-> st.cfg.touch[9:8] == 2'b00)
        else $error("limit bits not cleared");
    chk_soft_keeps_cfg: assert property (
        (soft_hit && !hard_hit && !reg_rd)
        |=> st.cfg == $past(st.cfg) && st.phase == touch_pkg::PH_CAL && st.calib_restart)
        else $error("soft reset disturbed configuration");
    chk_zero_hold: assert property (
        (st.scan_done && $past(mode_single) && $past(st.cfg.hold) == 16'h0000
         && $past(best_valid)) |-> st.cur_idx == $past(best_idx))
        else $error("zero hold did not replace");
    chk_two_no_hold: assert property (
        (st.scan_done && $past(mode_two)) |-> st.hold_cnt == 16'h0000)
        else $error("hold counted in two mode");

    cov_sleep_entry: cover property (st.phase == touch_pkg::PH_SCAN ##1 st.phase == touch_pkg::PH_SLEEP);
    cov_held_replace: cover property (st.scan_done && st.hold_cnt == 16'h0000 && $past(st.hold_cnt) != 16'h0000);
    cov_two_report: cover property (st.scan_done && $countones(st.touch_report) == 2 && $past(mode_two));
endmodule
`default_nettype wire

// >>> tb/host_bus_model.sv
// host side of the register strobe port: one-cycle write and read strobes
// assumes reg_rdata is registered and valid one cycle after the read edge
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] reg_rdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [11:0]      reg_addr,
    output logic [15:0]      reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_touch_low_power_and_selective_touch.sv
// self-checking bench for the scan scheduler and strongest-touch filter
// assumes shortened counts: 4 cycles per sensor scan, 3 cycles per ms
`timescale 1ns/1ps
`default_nettype none
module test_touch_low_power_and_selective_touch;
    localparam logic [11:0] ADDRS [6] = '{touch_pkg::ADDR_POWER_CFG, touch_pkg::ADDR_SLEEP_WAIT,
        touch_pkg::ADDR_HOLD_TIME, touch_pkg::ADDR_TOUCH_CFG, touch_pkg::ADDR_SLEEP_PERIOD,
        touch_pkg::ADDR_RANKING_CFG};
    localparam logic [15:0] VALS [6] = '{16'h5A50, 16'h1234, 16'hBEEF, 16'h0300, 16'h00C3, 16'h8021};
    localparam logic [15:0] MODE [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0100, 16'h0200};
    localparam logic [15:0] RANK [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h8000};
    localparam logic [7:0]  EXPR [5] = '{8'h02, 8'h03, 8'h07, 8'h04, 8'h05};
    logic                      clk_sys;
    logic                      reset;
    logic [7:0]                sensor_active;
    touch_pkg::sensor_sample_t smp;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [11:0]               reg_addr;
    logic [15:0]               reg_wdata;
    logic [15:0]               reg_rdata;
    logic                      scan_enable;
    logic                      scan_done;
    logic                      calib_restart;
    logic [7:0]                touch_report;
    int                        err_count = 0;
    int                        samples_checked = 0;
    int                        hi_n;
    logic                      pin_n;
    host_bus_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    touch_scan_control #(.SCAN_CYC(4), .MS_CYC(3)) dut (.clk_sys(clk_sys), .reset(reset),
        .hardware_reset_pin_n(pin_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .sensor_active(sensor_active), .sample(smp),
        .reg_rdata(reg_rdata), .scan_enable(scan_enable), .scan_done(scan_done),
        .calib_restart(calib_restart), .touch_report(touch_report));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    // bounded wait for n scan completions, ends on the negedge of the last one
    task automatic scan_wait(input int n);
        int k;
        k = 0;
        for (int i = 0; i < 2000 && k < n; i++) begin
            @(negedge clk_sys);
            if (scan_done === 1'b1) k++;
        end
        if (k < n) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic rep(input int n, input logic [7:0] exp);
        scan_wait(n);
        chk({8'h00, touch_report}, {8'h00, exp});
    endtask
    // a wait that used up its bound ends the run as a failure
    task automatic lim(input int n);
        if (n >= 500) begin
            err_count++;
            give_verdict();
        end
    endtask
    // counts sleep then scan cycles of one low power period
    task automatic lp_chk(input int hi, input int lo);
        int n;
        n = 0;
        while (scan_enable !== 1'b0 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        lim(n);
        n = 0;
        while (scan_enable === 1'b0 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        lim(n);
        chk(16'(n), 16'(lo));
        n = 0;
        while (scan_enable === 1'b1 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        lim(n);
        chk(16'(n), 16'(hi));
    endtask
    initial begin
        reset = 1'b1;
        pin_n = 1'b1;
        sensor_active = 8'h01;
        smp = '0;
        smp.touched = 8'hFF;
        smp.cap[0] = 16'h01F4;
        smp.thr[0] = 16'h0064;
        smp.cap[1] = 16'h0258;
        smp.thr[1] = 16'h01F4;
        smp.cap[2] = 16'h01C2;
        smp.cap[3] = 16'h0032;
        smp.thr[3] = 16'h0064;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rchk(ADDRS[i], 16'h0000);
        rchk(12'h010, 16'h0000);
        for (int i = 0; i < 6; i++) host.wr(ADDRS[i], VALS[i]);
        host.wr(touch_pkg::ADDR_SOFT_RESET, 16'h0000);
        @(negedge clk_sys);
        chk({15'h0000, calib_restart}, 16'h0001);
        for (int i = 0; i < 6; i++) rchk(ADDRS[i], VALS[i]);
        host.wr(touch_pkg::ADDR_HARD_RESET, 16'h0000);
        for (int i = 0; i < 6; i++) rchk(ADDRS[i], 16'h0000);
        rep(2, 8'h07);
        for (int i = 0; i < 5; i++) begin
            host.wr(touch_pkg::ADDR_TOUCH_CFG, MODE[i]);
            host.wr(touch_pkg::ADDR_RANKING_CFG, RANK[i]);
            rep(2, EXPR[i]);
        end
        // hold of 2 scans: replacement on the third scan end
        host.wr(touch_pkg::ADDR_RANKING_CFG, 16'h0000);
        host.wr(touch_pkg::ADDR_TOUCH_CFG, 16'h0100);
        host.wr(touch_pkg::ADDR_HOLD_TIME, 16'h0002);
        rep(2, 8'h02);
        @(posedge clk_sys);
        smp.cap[0] <= 16'h02BC;
        rep(1, 8'h02);
        rep(1, 8'h02);
        rep(1, 8'h01);
        host.wr(touch_pkg::ADDR_TOUCH_CFG, 16'h0200);
        rep(2, 8'h03);
        @(posedge clk_sys);
        smp.cap[2] <= 16'h0320;
        rep(1, 8'h05);
        host.wr(touch_pkg::ADDR_HOLD_TIME, 16'h0000);
        host.wr(touch_pkg::ADDR_TOUCH_CFG, 16'h0100);
        rep(2, 8'h04);
        @(posedge clk_sys);
        smp.cap[1] <= 16'h0384;
        rep(1, 8'h02);
        @(posedge clk_sys);
        smp.touched <= 8'h00;
        host.wr(touch_pkg::ADDR_SLEEP_PERIOD, 16'h0002);
        host.wr(touch_pkg::ADDR_POWER_CFG, 16'h0002);
        scan_wait(1);
        lp_chk(4, 6);
        @(posedge clk_sys);
        sensor_active <= 8'h03;
        scan_wait(2);
        lp_chk(8, 6);
        host.wr(touch_pkg::ADDR_SLEEP_WAIT, 16'h0003);
        smp.touched <= 8'hFF;
        scan_wait(2);
        hi_n = 0;
        repeat (40) begin
            @(negedge clk_sys);
            if (scan_enable === 1'b1) hi_n++;
        end
        chk(16'(hi_n), 16'h0028);
        // once touches stop, sleep resumes after the wait lapses
        @(posedge clk_sys);
        smp.touched <= 8'h00;
        lp_chk(8, 6);
        // pin reset clears configuration like a hard reset
        @(posedge clk_sys);
        pin_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        pin_n <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(ADDRS[i], 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
